// *** src/psp_profile_params.sv ***
// Speed-profile parameter registers with pre-registers, direct and indirect host access,
// and derived ramp timing. Assumes a synchronous host port with 8-bit address and 32-bit data on ref_clk.
`timescale 1ns/100ps
module psp_profile_params
  import psp_pkg::*;
#(
  parameter int REF_HZ = psp_pkg::PSP_REF_HZ
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hostSel,
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic altByteOrder,
  input wire logic [psp_pkg::PSP_ADDR_W-1:0] hostAddr,
  input wire logic [psp_pkg::PSP_DATA_W-1:0] hostWdata,
  output logic [psp_pkg::PSP_DATA_W-1:0] hostRdata,
  output logic hostAck,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [psp_pkg::PSP_DATA_W-1:0] cmdWdata,
  output logic [psp_pkg::PSP_DATA_W-1:0] cmdRdata,
  output logic cmdDone,
  output logic cmdBad,
  input wire logic opStart,
  input wire logic opRunning,
  input wire logic rampShapeSelect,
  input wire logic [15:0] accelRate,
  input wire logic [15:0] topSpeedStep,
  input wire logic [15:0] baseSpeedStep,
  input wire logic [31:0] remainingPulses,
  input wire logic [23:0] slowdownAutoValue,
  output logic [15:0] decelRateEff,
  output logic [11:0] speedMagnification,
  output logic [15:0] auxSpeedStep,
  output logic [16:0] accelSectionEff,
  output logic [16:0] decelSectionEff,
  output logic [47:0] accelCycles,
  output logic [47:0] decelCycles,
  output logic [31:0] stepPeriodCycles,
  output logic [31:0] speedMultMilli,
  output logic slowdownReq,
  output logic writeWhileRun
);
  if (REF_HZ < 1) begin : g_ref_check
    $error("REF_HZ must be positive");
  end
  typedef struct packed {
    logic [15:0] decelRate;
    logic [15:0] decelRateNx;
    logic [11:0] mag;
    logic [11:0] magNx;
    logic [14:0] asec;
    logic [14:0] asecNx;
    logic [14:0] dsec;
    logic [14:0] dsecNx;
    logic [15:0] aux;
    logic [31:0] hrd;
    logic hack;
    logic [31:0] crd;
    logic cdone;
    logic cbad;
    logic slow;
    logic wwr;
    logic [31:0] multMilli;
  } psp_st_s;
  psp_st_s state_reg;
  psp_st_s state_next;
  logic [15:0] decelRateUse;
  logic [7:0] dirOfs;
  logic isWorkWr;
  logic [7:0] altAddr;
  logic [47:0] accCyc;
  logic [47:0] decCyc;
  logic [16:0] accSec;
  logic [16:0] decSec;
  // Remap the alternate byte-order addresses to the primary map
  always_comb begin
    unique case (hostAddr)
      PSP_ALT_AUX: altAddr = PSP_OFS_AUX;
      PSP_ALT_DSEC: altAddr = PSP_OFS_DSEC;
      PSP_ALT_ASEC: altAddr = PSP_OFS_ASEC;
      PSP_ALT_MAG: altAddr = PSP_OFS_MAG;
      PSP_ALT_DRATE: altAddr = PSP_OFS_DRATE;
      PSP_ALT_DSEC_NX: altAddr = PSP_OFS_DSEC_NX;
      PSP_ALT_ASEC_NX: altAddr = PSP_OFS_ASEC_NX;
      PSP_ALT_MAG_NX: altAddr = PSP_OFS_MAG_NX;
      PSP_ALT_DRATE_NX: altAddr = PSP_OFS_DRATE_NX;
      default: altAddr = 8'h00;
    endcase
    dirOfs = altByteOrder ? altAddr : hostAddr;
  end
  assign decelRateUse = (state_reg.decelRate == 16'h0000) ? accelRate : state_reg.decelRate;
  psp_ramp_time #(.RATE_W(16), .SEC_W(PSP_SEC_W)) accRamp (
    .ref_clk(ref_clk),
    .srst(srst),
    .sCurve(rampShapeSelect),
    .topStep(topSpeedStep),
    .baseStep(baseSpeedStep),
    .rate(accelRate),
    .section(state_reg.asec),
    .rampCycles(accCyc),
    .sectionEff(accSec)
  );
  psp_ramp_time #(.RATE_W(16), .SEC_W(PSP_SEC_W)) decRamp (
    .ref_clk(ref_clk),
    .srst(srst),
    .sCurve(rampShapeSelect),
    .topStep(topSpeedStep),
    .baseStep(baseSpeedStep),
    .rate(decelRateUse),
    .section(state_reg.dsec),
    .rampCycles(decCyc),
    .sectionEff(decSec)
  );
  always_comb begin
    state_next = state_reg;
    state_next.hack = 1'b0;
    state_next.cdone = 1'b0;
    state_next.cbad = 1'b0;
    isWorkWr = 1'b0;
    // Pre-registers load working copies at operation start
    if (opStart) begin
      state_next.decelRate = state_reg.decelRateNx;
      state_next.mag = state_reg.magNx;
      state_next.asec = state_reg.asecNx;
      state_next.dsec = state_reg.dsecNx;
    end
    // Direct access
    if (hostSel && (hostWr || hostRd)) begin
      state_next.hack = 1'b1;
      state_next.hrd = 32'h00000000;
      unique case (dirOfs)
        PSP_OFS_AUX: begin
          if (hostWr) state_next.aux = hostWdata[15:0];
          state_next.hrd = {16'h0000, state_reg.aux};
          isWorkWr = hostWr;
        end
        PSP_OFS_DSEC: begin
          if (hostWr) state_next.dsec = hostWdata[14:0];
          state_next.hrd = {17'h00000, state_reg.dsec};
          isWorkWr = hostWr;
        end
        PSP_OFS_ASEC: begin
          if (hostWr) state_next.asec = hostWdata[14:0];
          state_next.hrd = {17'h00000, state_reg.asec};
          isWorkWr = hostWr;
        end
        PSP_OFS_MAG: begin
          if (hostWr) state_next.mag = hostWdata[11:0];
          state_next.hrd = {20'h00000, state_reg.mag};
          isWorkWr = hostWr;
        end
        PSP_OFS_DRATE: begin
          if (hostWr) state_next.decelRate = hostWdata[15:0];
          state_next.hrd = {16'h0000, state_reg.decelRate};
          isWorkWr = hostWr;
        end
        PSP_OFS_DSEC_NX: begin
          if (hostWr) state_next.dsecNx = hostWdata[14:0];
          state_next.hrd = {17'h00000, state_reg.dsecNx};
        end
        PSP_OFS_ASEC_NX: begin
          if (hostWr) state_next.asecNx = hostWdata[14:0];
          state_next.hrd = {17'h00000, state_reg.asecNx};
        end
        PSP_OFS_MAG_NX: begin
          if (hostWr) state_next.magNx = hostWdata[11:0];
          state_next.hrd = {20'h00000, state_reg.magNx};
        end
        PSP_OFS_DRATE_NX: begin
          if (hostWr) state_next.decelRateNx = hostWdata[15:0];
          state_next.hrd = {16'h0000, state_reg.decelRateNx};
        end
        default: state_next.hrd = 32'h00000000;
      endcase
    end
    // Indirect access by command code
    if (cmdValid) begin
      state_next.cdone = 1'b1;
      state_next.crd = 32'h00000000;
      unique case (cmdCode)
        PSP_CMD_RD_DRATE: state_next.crd = {16'h0000, state_reg.decelRate};
        PSP_CMD_RD_DRATE_NX: state_next.crd = {16'h0000, state_reg.decelRateNx};
        PSP_CMD_WR_DRATE: begin
          state_next.decelRate = cmdWdata[15:0];
          isWorkWr = 1'b1;
        end
        PSP_CMD_WR_DRATE_NX: state_next.decelRateNx = cmdWdata[15:0];
        PSP_CMD_RD_MAG: state_next.crd = {20'h00000, state_reg.mag};
        PSP_CMD_RD_MAG_NX: state_next.crd = {20'h00000, state_reg.magNx};
        PSP_CMD_WR_MAG: begin
          state_next.mag = cmdWdata[11:0];
          isWorkWr = 1'b1;
        end
        PSP_CMD_WR_MAG_NX: state_next.magNx = cmdWdata[11:0];
        PSP_CMD_RD_ASEC: state_next.crd = {17'h00000, state_reg.asec};
        PSP_CMD_RD_ASEC_NX: state_next.crd = {17'h00000, state_reg.asecNx};
        PSP_CMD_WR_ASEC: begin
          state_next.asec = cmdWdata[14:0];
          isWorkWr = 1'b1;
        end
        PSP_CMD_WR_ASEC_NX: state_next.asecNx = cmdWdata[14:0];
        PSP_CMD_RD_DSEC: state_next.crd = {17'h00000, state_reg.dsec};
        PSP_CMD_RD_DSEC_NX: state_next.crd = {17'h00000, state_reg.dsecNx};
        PSP_CMD_WR_DSEC: begin
          state_next.dsec = cmdWdata[14:0];
          isWorkWr = 1'b1;
        end
        PSP_CMD_WR_DSEC_NX: state_next.dsecNx = cmdWdata[14:0];
        PSP_CMD_RD_AUX: state_next.crd = {16'h0000, state_reg.aux};
        PSP_CMD_WR_AUX: begin
          state_next.aux = cmdWdata[15:0];
          isWorkWr = 1'b1;
        end
        default: state_next.cbad = 1'b1;
      endcase
    end
    // Sticky flag: a working write while running; set wins over the clear at start
    if (isWorkWr && opRunning) begin
      state_next.wwr = 1'b1;
    end else if (opStart) begin
      state_next.wwr = 1'b0;
    end
    state_next.slow = opRunning && (remainingPulses <= {8'h00, slowdownAutoValue});
    // Multiplier in thousandths of pulses per second per step
    state_next.multMilli = 32'((64'(REF_HZ) * 64'd1000) /
      (64'(state_reg.mag + 13'd1) * 64'(PSP_MAG_SCALE)));
    if (srst) begin
      state_next = '0;
      state_next.decelRate = PSP_RST_RATE;
      state_next.decelRateNx = PSP_RST_RATE;
      state_next.mag = PSP_RST_MAG;
      state_next.magNx = PSP_RST_MAG;
      state_next.asec = PSP_RST_SEC;
      state_next.asecNx = PSP_RST_SEC;
      state_next.dsec = PSP_RST_SEC;
      state_next.dsecNx = PSP_RST_SEC;
      state_next.aux = PSP_RST_AUX;
    end
  end
  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
  end
  assign hostRdata = state_reg.hrd;
  assign hostAck = state_reg.hack;
  assign cmdRdata = state_reg.crd;
  assign cmdDone = state_reg.cdone;
  assign cmdBad = state_reg.cbad;
  assign decelRateEff = decelRateUse;
  assign speedMagnification = state_reg.mag;
  assign auxSpeedStep = state_reg.aux;
  assign accelSectionEff = accSec;
  assign decelSectionEff = decSec;
  assign accelCycles = accCyc;
  assign decelCycles = decCyc;
  // One step of speed is one pulse per (magnification+1)*65536 clocks
  assign stepPeriodCycles = 32'(state_reg.mag + 13'd1) * 32'(PSP_MAG_SCALE);
  assign speedMultMilli = state_reg.multMilli;
  assign slowdownReq = state_reg.slow;
  assign writeWhileRun = state_reg.wwr;
endmodule

// *** src/psp_pkg.sv ***
// Package for the speed-profile parameter block: register offsets, command codes, widths.
// Assumes an 8-bit host address, a 32-bit host data path and one 100 MHz clock.
package psp_pkg;
  localparam int PSP_ADDR_W = 8;
  localparam int PSP_DATA_W = 32;
  // Direct map, primary byte order
  localparam logic [7:0] PSP_OFS_AUX = 8'h90;
  localparam logic [7:0] PSP_OFS_DSEC = 8'h94;
  localparam logic [7:0] PSP_OFS_ASEC = 8'h98;
  localparam logic [7:0] PSP_OFS_MAG = 8'ha8;
  localparam logic [7:0] PSP_OFS_DRATE = 8'hac;
  localparam logic [7:0] PSP_OFS_DSEC_NX = 8'hcc;
  localparam logic [7:0] PSP_OFS_ASEC_NX = 8'hd0;
  localparam logic [7:0] PSP_OFS_MAG_NX = 8'he0;
  localparam logic [7:0] PSP_OFS_DRATE_NX = 8'he4;
  // Direct map, alternate byte order
  localparam logic [7:0] PSP_ALT_AUX = 8'h6c;
  localparam logic [7:0] PSP_ALT_DSEC = 8'h68;
  localparam logic [7:0] PSP_ALT_ASEC = 8'h64;
  localparam logic [7:0] PSP_ALT_MAG = 8'h54;
  localparam logic [7:0] PSP_ALT_DRATE = 8'h50;
  localparam logic [7:0] PSP_ALT_DSEC_NX = 8'h30;
  localparam logic [7:0] PSP_ALT_ASEC_NX = 8'h2c;
  localparam logic [7:0] PSP_ALT_MAG_NX = 8'h1c;
  localparam logic [7:0] PSP_ALT_DRATE_NX = 8'h18;
  // Indirect command codes
  localparam logic [7:0] PSP_CMD_RD_DRATE = 8'hd4;
  localparam logic [7:0] PSP_CMD_RD_DRATE_NX = 8'hc4;
  localparam logic [7:0] PSP_CMD_WR_DRATE = 8'h94;
  localparam logic [7:0] PSP_CMD_WR_DRATE_NX = 8'h84;
  localparam logic [7:0] PSP_CMD_RD_MAG = 8'hd5;
  localparam logic [7:0] PSP_CMD_RD_MAG_NX = 8'hc5;
  localparam logic [7:0] PSP_CMD_WR_MAG = 8'h95;
  localparam logic [7:0] PSP_CMD_WR_MAG_NX = 8'h85;
  localparam logic [7:0] PSP_CMD_RD_ASEC = 8'hd9;
  localparam logic [7:0] PSP_CMD_RD_ASEC_NX = 8'hc9;
  localparam logic [7:0] PSP_CMD_WR_ASEC = 8'h99;
  localparam logic [7:0] PSP_CMD_WR_ASEC_NX = 8'h89;
  localparam logic [7:0] PSP_CMD_RD_DSEC = 8'hda;
  localparam logic [7:0] PSP_CMD_RD_DSEC_NX = 8'hca;
  localparam logic [7:0] PSP_CMD_WR_DSEC = 8'h9a;
  localparam logic [7:0] PSP_CMD_WR_DSEC_NX = 8'h8a;
  localparam logic [7:0] PSP_CMD_RD_AUX = 8'hdb;
  localparam logic [7:0] PSP_CMD_WR_AUX = 8'h9b;
  // Field widths and reset values
  localparam int PSP_RATE_W = 16;
  localparam int PSP_MAG_W = 12;
  localparam int PSP_SEC_W = 15;
  localparam logic [15:0] PSP_RST_RATE = 16'h0000;
  localparam logic [11:0] PSP_RST_MAG = 12'h12b;
  localparam logic [14:0] PSP_RST_SEC = 15'h0000;
  localparam logic [15:0] PSP_RST_AUX = 16'h0001;
  // Cycle scale factors of the ramp and step-period formulas, and the clock rate
  localparam int PSP_LIN_SCALE = 4;
  localparam int PSP_FULLS_SCALE = 8;
  localparam int PSP_MAG_SCALE = 65536;
  localparam int PSP_REF_HZ = 100_000_000;
endpackage

// *** src/psp_ramp_time.sv ***
// Ramp length in clock cycles for one ramp direction.
// Assumes step settings are stable while a result is read.
`timescale 1ns/100ps
module psp_ramp_time
  import psp_pkg::*;
#(
  parameter int RATE_W = 16,
  parameter int SEC_W = 15
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic sCurve,
  input wire logic [15:0] topStep,
  input wire logic [15:0] baseStep,
  input wire logic [RATE_W-1:0] rate,
  input wire logic [SEC_W-1:0] section,
  output logic [47:0] rampCycles,
  output logic [16:0] sectionEff
);
  typedef struct packed {
    logic [47:0] cyc;
    logic [16:0] sec;
  } psp_rt_s;
  psp_rt_s state_reg;
  psp_rt_s state_next;
  logic [16:0] span;
  logic [17:0] term;
  always_comb begin
    span = (topStep > baseStep) ? {1'b0, topStep - baseStep} : 17'h00000;
    state_next = state_reg;
    if (!sCurve) begin
      term = {1'b0, span};
      state_next.cyc = 48'(term) * (48'(rate) + 48'd1) * 48'(PSP_LIN_SCALE);
      state_next.sec = 17'h00000;
    end else if (section == '0) begin
      term = {1'b0, span};
      state_next.cyc = 48'(term) * (48'(rate) + 48'd1) * 48'(PSP_FULLS_SCALE);
      state_next.sec = {1'b0, span[16:1]};
    end else begin
      term = {1'b0, span} + {2'b00, section, 1'b0};
      state_next.cyc = 48'(term) * (48'(rate) + 48'd1) * 48'(PSP_LIN_SCALE);
      state_next.sec = 17'(section);
    end
    if (srst) begin
      state_next = '0;
    end
  end
  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
  end
  assign rampCycles = state_reg.cyc;
  assign sectionEff = state_reg.sec;
endmodule

// *** bench/psp_profile_params_properties.sv ***
// Checker for the speed-profile parameter block.
// Assumes one clock and the synchronous reset of the top module.
`timescale 1ns/100ps
module psp_profile_params_properties (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hostSel,
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic hostAck,
  input wire logic cmdValid,
  input wire logic cmdDone,
  input wire logic opRunning,
  input wire logic rampShapeSelect,
  input wire logic [15:0] accelRate,
  input wire logic [15:0] topSpeedStep,
  input wire logic [15:0] baseSpeedStep,
  input wire logic [31:0] remainingPulses,
  input wire logic [23:0] slowdownAutoValue,
  input wire logic [15:0] decelRateEff,
  input wire logic [11:0] speedMagnification,
  input wire logic [16:0] accelSectionEff,
  input wire logic [47:0] decelCycles,
  input wire logic [31:0] stepPeriodCycles,
  input wire logic slowdownReq
);
  import psp_pkg::*;
  logic [15:0] span;
  logic [47:0] linDec;
  logic slowCond;
  assign span = (topSpeedStep > baseSpeedStep) ? topSpeedStep - baseSpeedStep : 16'h0;
  assign linDec = 48'(span) * (48'(decelRateEff) + 48'h1) * 48'h4;
  assign slowCond = opRunning && (remainingPulses <= {8'h0, slowdownAutoValue});
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_ack_follows_req: assert property (hostSel && (hostWr || hostRd) |=> hostAck)
    else $error("host access not acknowledged");
  a_ack_no_req: assert property (!(hostSel && (hostWr || hostRd)) |=> !hostAck)
    else $error("acknowledge without access");
  a_cmd_done_next: assert property (cmdValid |=> cmdDone)
    else $error("command not completed");
  a_rate_borrow: assert property (decelRateEff == 16'h0 |-> accelRate == 16'h0)
    else $error("zero decel rate not replaced");
  a_step_period: assert property (stepPeriodCycles == (32'(speedMagnification) + 32'h1) * 32'h10000)
    else $error("step period wrong");
  a_slowdown_point: assert property (!$past(srst) |-> slowdownReq == $past(slowCond))
    else $error("slowdown request wrong");
  a_linear_decel: assert property (!$past(srst) && !$past(rampShapeSelect) |-> decelCycles == $past(linDec))
    else $error("linear decel cycles wrong");
  a_linear_section: assert property (!rampShapeSelect ##1 !rampShapeSelect |-> accelSectionEff == 17'h0)
    else $error("section active in linear mode");
  c_ack: cover property (hostAck);
  c_done: cover property (cmdDone);
  c_slow: cover property (slowdownReq);
endmodule
bind psp_profile_params psp_profile_params_properties u_props (.ref_clk(ref_clk), .srst(srst),
  .hostSel(hostSel), .hostWr(hostWr), .hostRd(hostRd), .hostAck(hostAck), .cmdValid(cmdValid),
  .cmdDone(cmdDone), .opRunning(opRunning), .rampShapeSelect(rampShapeSelect), .accelRate(accelRate),
  .topSpeedStep(topSpeedStep), .baseSpeedStep(baseSpeedStep), .remainingPulses(remainingPulses),
  .slowdownAutoValue(slowdownAutoValue), .decelRateEff(decelRateEff), .speedMagnification(speedMagnification),
  .accelSectionEff(accelSectionEff), .decelCycles(decelCycles), .stepPeriodCycles(stepPeriodCycles),
  .slowdownReq(slowdownReq));

// *** bench/psp_host_model.sv ***
// Host processor model: direct register cycles and indirect command cycles.
// Assumes the device answers one cycle after the request edge.
`timescale 1ns/100ps
module psp_host_model (
  input wire logic ref_clk,
  output logic hostSel,
  output logic hostWr,
  output logic hostRd,
  output logic [psp_pkg::PSP_ADDR_W-1:0] hostAddr,
  output logic [psp_pkg::PSP_DATA_W-1:0] hostWdata,
  input wire logic [psp_pkg::PSP_DATA_W-1:0] hostRdata,
  input wire logic hostAck,
  output logic cmdValid,
  output logic [7:0] cmdCode,
  output logic [psp_pkg::PSP_DATA_W-1:0] cmdWdata,
  input wire logic [psp_pkg::PSP_DATA_W-1:0] cmdRdata,
  input wire logic cmdDone,
  input wire logic cmdBad
);
  import psp_pkg::*;
  initial begin
    {hostSel, hostWr, hostRd, cmdValid} = 4'h0;
    hostAddr = 8'h00;
    hostWdata = 32'h0;
    cmdCode = 8'h00;
    cmdWdata = 32'h0;
  end
  // Released lines show inverted values so stale data never passes
  task automatic dir(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk) #1;
    {hostSel, hostWr, hostRd} = {1'b1, wr, !wr};
    hostAddr = a;
    hostWdata = d;
    @(posedge ref_clk) #1;
    {hostSel, hostWr, hostRd} = 3'h0;
    hostAddr = ~a;
    hostWdata = ~d;
    q = hostAck ? hostRdata : 32'hdead0001;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] d, output logic [31:0] q, output logic bad);
    @(posedge ref_clk) #1;
    cmdValid = 1'b1;
    cmdCode = c;
    cmdWdata = d;
    @(posedge ref_clk) #1;
    cmdValid = 1'b0;
    cmdCode = ~c;
    cmdWdata = ~d;
    q = cmdDone ? cmdRdata : 32'hdead0002;
    bad = cmdBad;
  endtask
endmodule

// *** bench/psp_profile_params_tb.sv ***
// Testbench for the speed-profile parameter block driven by a host model.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
module psp_profile_params_tb;
  import psp_pkg::*;
  logic ref_clk, srst, hostSel, hostWr, hostRd, altByteOrder, hostAck, cmdValid, cmdDone, cmdBad, bad;
  logic opStart, opRunning, rampShapeSelect, slowdownReq, writeWhileRun;
  logic [7:0] hostAddr, cmdCode;
  logic [31:0] hostWdata, hostRdata, cmdWdata, cmdRdata, remainingPulses, stepPeriodCycles, speedMultMilli, q;
  logic [15:0] accelRate, topSpeedStep, baseSpeedStep, decelRateEff, auxSpeedStep;
  logic [23:0] slowdownAutoValue;
  logic [11:0] speedMagnification;
  logic [16:0] accelSectionEff, decelSectionEff;
  logic [47:0] accelCycles, decelCycles;
  int failures, checks;
  psp_host_model u_host (.ref_clk(ref_clk), .hostSel(hostSel), .hostWr(hostWr), .hostRd(hostRd),
    .hostAddr(hostAddr), .hostWdata(hostWdata), .hostRdata(hostRdata), .hostAck(hostAck), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdWdata(cmdWdata), .cmdRdata(cmdRdata), .cmdDone(cmdDone), .cmdBad(cmdBad));
  psp_profile_params u_dut (.ref_clk(ref_clk), .srst(srst), .hostSel(hostSel), .hostWr(hostWr),
    .hostRd(hostRd), .altByteOrder(altByteOrder), .hostAddr(hostAddr), .hostWdata(hostWdata),
    .hostRdata(hostRdata), .hostAck(hostAck), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdWdata(cmdWdata),
    .cmdRdata(cmdRdata), .cmdDone(cmdDone), .cmdBad(cmdBad), .opStart(opStart), .opRunning(opRunning),
    .rampShapeSelect(rampShapeSelect), .accelRate(accelRate), .topSpeedStep(topSpeedStep),
    .baseSpeedStep(baseSpeedStep), .remainingPulses(remainingPulses), .slowdownAutoValue(slowdownAutoValue),
    .decelRateEff(decelRateEff), .speedMagnification(speedMagnification), .auxSpeedStep(auxSpeedStep),
    .accelSectionEff(accelSectionEff), .decelSectionEff(decelSectionEff), .accelCycles(accelCycles),
    .decelCycles(decelCycles), .stepPeriodCycles(stepPeriodCycles), .speedMultMilli(speedMultMilli),
    .slowdownReq(slowdownReq), .writeWhileRun(writeWhileRun));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic ck(input logic [47:0] g, input logic [47:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic rdd(input logic [7:0] a, input logic [31:0] e);
    u_host.dir(1'b0, a, 32'h0, q);
    ck(48'(q), 48'(e));
  endtask
  task automatic rdc(input logic [7:0] c, input logic [31:0] e);
    u_host.cmd(c, 32'h0, q, bad);
    ck(48'(q), 48'(e));
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse();
    opStart = 1'b1;
    step(1);
    opStart = 1'b0;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_reset();
    rdd(PSP_OFS_DRATE, 32'h0);
    rdd(PSP_OFS_MAG, 32'h12b);
    rdd(PSP_OFS_AUX, 32'h1);
    rdd(PSP_OFS_MAG_NX, 32'h12b);
    rdd(8'h00, 32'h0);
  endtask
  task automatic t_prereg(input logic [7:0] wrNx, rdNx, rd, input logic [31:0] v, old);
    u_host.cmd(wrNx, v, q, bad);
    rdc(rdNx, v);
    rdc(rd, old);
    pulse();
    rdc(rd, v);
  endtask
  task automatic t_ramp();
    step(2);
    ck(decelCycles, 48'h320 * 48'h4 * 48'h4);
    ck(48'(accelSectionEff), 48'h0);
    rampShapeSelect = 1'b1;
    step(2);
    ck(decelCycles, 48'h320 * 48'h4 * 48'h8);
    ck(48'(decelSectionEff), 48'h190);
    ck(48'(accelSectionEff), 48'h190);
    u_host.cmd(PSP_CMD_WR_DSEC, 32'h32, q, bad);
    u_host.cmd(PSP_CMD_WR_ASEC, 32'h32, q, bad);
    step(2);
    ck(decelCycles, 48'h384 * 48'h4 * 48'h4);
    ck(accelCycles, 48'h384 * 48'h3 * 48'h4);
    ck(48'(accelSectionEff), 48'h32);
    ck(48'(decelSectionEff), 48'h32);
    rdc(PSP_CMD_RD_ASEC, 32'h32);
    rdc(PSP_CMD_RD_DSEC, 32'h32);
  endtask
  task automatic t_rate();
    u_host.cmd(PSP_CMD_WR_DRATE, 32'h0, q, bad);
    ck(48'(decelRateEff), 48'(accelRate));
    rdc(PSP_CMD_RD_DRATE, 32'h0);
    ck(48'(speedMagnification), 48'hfff);
    ck(48'(stepPeriodCycles), 48'h1000 * 48'h10000);
    ck(48'(speedMultMilli), 48'(64'h3e8 * PSP_REF_HZ / 64'h10000000));
  endtask
  task automatic t_alt();
    altByteOrder = 1'b1;
    u_host.dir(1'b1, PSP_ALT_DRATE_NX, 32'h7, q);
    rdd(PSP_ALT_DRATE_NX, 32'h7);
    rdd(PSP_ALT_DRATE, 32'h0);
    altByteOrder = 1'b0;
    rdd(PSP_OFS_DRATE_NX, 32'h7);
  endtask
  task automatic t_aux();
    u_host.cmd(PSP_CMD_WR_AUX, 32'h1234, q, bad);
    ck(48'(bad), 48'h0);
    rdc(PSP_CMD_RD_AUX, 32'h1234);
    ck(48'(auxSpeedStep), 48'h1234);
    u_host.cmd(8'hcb, 32'h0, q, bad);
    ck(48'(bad), 48'h1);
  endtask
  task automatic t_run();
    opRunning = 1'b1;
    step(2);
    ck(48'(slowdownReq), 48'h1);
    remainingPulses = 32'hb;
    step(2);
    ck(48'(slowdownReq), 48'h0);
    u_host.dir(1'b1, PSP_OFS_AUX, 32'h5, q);
    step(1);
    ck(48'(writeWhileRun), 48'h1);
    opRunning = 1'b0;
    pulse();
    step(1);
    ck(48'(writeWhileRun), 48'h0);
  endtask
  initial begin
    {srst, altByteOrder, opStart, opRunning, rampShapeSelect} = 5'h10;
    accelRate = 16'h2;
    topSpeedStep = 16'h3e8;
    baseSpeedStep = 16'hc8;
    remainingPulses = 32'ha;
    slowdownAutoValue = 24'ha;
    repeat (8) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_prereg(PSP_CMD_WR_DRATE_NX, PSP_CMD_RD_DRATE_NX, PSP_CMD_RD_DRATE, 32'h3, 32'h0);
    t_prereg(PSP_CMD_WR_MAG_NX, PSP_CMD_RD_MAG_NX, PSP_CMD_RD_MAG, 32'hfff, 32'h12b);
    t_ramp();
    t_rate();
    t_alt();
    t_aux();
    t_run();
    results();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    results();
  end
endmodule
